// ===== common/scb_pkg.sv
// shared constants, types and decode functions for the setup configuration bank
package scb_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_SETUP_BASE = 8'h19;
    localparam logic [7:0] IDX_SETUP_LAST = 8'h20;
    localparam logic [7:0] IDX_CHAN_ROUTE = 8'h30;
    localparam logic [7:0] IDX_FE_STATUS = 8'h31;
    localparam int NUM_SETUPS_DOC = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [10:0] CHAN_ROUTE_RESET = 11'h000;

    // ------------------------------------------------------------------
    // setup word fields
    // ------------------------------------------------------------------
    localparam int SRC1_MAG_LSB = 13;
    localparam int SRC0_MAG_LSB = 10;
    localparam int BURNOUT_LSB = 8;
    localparam int REFPOS_BUF_BIT = 7;
    localparam int REFNEG_BUF_BIT = 6;
    localparam int REF_SEL_LSB = 4;
    localparam int GAIN_LSB = 1;
    localparam int BYPASS_BIT = 0;

    // ------------------------------------------------------------------
    // channel route word fields
    // ------------------------------------------------------------------
    localparam int SRC0_ROUTE_LSB = 0;
    localparam int SRC1_ROUTE_LSB = 4;
    localparam int SETUP_SEL_LSB = 8;

    // ------------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------------
    localparam int ST_GAIN_LSB = 0;
    localparam int ST_SRC0_RSVD_BIT = 8;
    localparam int ST_SRC1_RSVD_BIT = 9;
    localparam int ST_SETUP_LSB = 10;
    localparam int ST_BYPASS_BIT = 13;

    // ------------------------------------------------------------------
    // current values in nanoamps
    // ------------------------------------------------------------------
    localparam int CUR_W = 18;
    localparam int BURN_W = 12;
    localparam logic [17:0] CUR_OFF = 18'h00000;
    localparam logic [17:0] CUR_100NA = 18'd100;
    localparam logic [17:0] CUR_10UA = 18'd10000;
    localparam logic [17:0] CUR_20UA = 18'd20000;
    localparam logic [17:0] CUR_50UA = 18'd50000;
    localparam logic [17:0] CUR_100UA = 18'd100000;
    localparam logic [17:0] CUR_150UA = 18'd150000;
    localparam logic [17:0] CUR_200UA = 18'd200000;
    localparam logic [11:0] BURN_OFF = 12'h000;
    localparam logic [11:0] BURN_HALF_UA = 12'd500;
    localparam logic [11:0] BURN_2UA = 12'd2000;

    typedef enum logic [1:0] {
        REF_EXT_PAIR_A = 2'b00,
        REF_EXT_PAIR_B = 2'b01,
        REF_INTERNAL = 2'b10,
        REF_SUPPLY = 2'b11
    } scb_ref_pair_e;

    function automatic logic [17:0] source_current_na(input logic [2:0] code);
        case (code)
            3'h1: source_current_na = CUR_10UA;
            3'h2: source_current_na = CUR_20UA;
            3'h3: source_current_na = CUR_50UA;
            3'h4: source_current_na = CUR_100UA;
            3'h5: source_current_na = CUR_150UA;
            3'h6: source_current_na = CUR_200UA;
            3'h7: source_current_na = CUR_100NA;
            default: source_current_na = CUR_OFF;
        endcase
    endfunction

    function automatic logic [11:0] burnout_current_na(input logic [1:0] code);
        case (code)
            2'h1: burnout_current_na = BURN_HALF_UA;
            2'h2: burnout_current_na = BURN_2UA;
            default: burnout_current_na = BURN_OFF;
        endcase
    endfunction

    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction

endpackage

// ===== core/scb_bank.sv
// setup configuration register bank with apb slave and front end outputs
// ----------------------------------------------------------------------
// Functional notes
// - eight 16-bit setup registers at indices 0x19..0x20, reset zero, chosen by channel
// - bits 15:13 set source 1 current: off, 10..200 uA, 111 gives 100 nA
// - bits 12:10 set source 0 current: off, 10, 50, 100 uA printed
// - bits 9:8 set burnout current: off, half uA, two uA
// - bit 7 turns on the positive reference buffer
// - bit 6 bypasses negative reference buffer at 0, enables at 1
// - bits 5:4 pick reference: ext pair a, ext pair b, internal, supplies
// - bits 3:1 set amplifier gain to two to the code power
// - bit 0 bypasses amplifier, gain field ignored, gain forced to one
// - channel bits 3:0 route source 0 to one of eight input pins
// - source 1 routing uses the same code to pin map
// - source 1 routing sits in channel bits 7:4, reset zero, 0000 is pin 0
// ----------------------------------------------------------------------
//
// The APB slave port is this design's own decision.
module scb_bank #(
    parameter int NUM_SETUPS = scb_pkg::NUM_SETUPS_DOC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [17:0] src0_current_na,
    output logic [17:0] src1_current_na,
    output logic [11:0] burnout_current_na,
    output logic refpos_buffer_en,
    output logic refneg_buffer_en,
    output logic [1:0] ref_pair_sel,
    output logic amp_bypass,
    output logic [7:0] amp_gain,
    output logic [7:0] src0_pin_en,
    output logic [7:0] src1_pin_en
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (NUM_SETUPS < 1 || NUM_SETUPS > scb_pkg::NUM_SETUPS_DOC) begin : g_bad_setups
        $error("NUM_SETUPS must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [7:0] acc_idx;
    logic aligned;
    logic hit_setup;
    logic hit_route;
    logic hit_status;
    logic [2:0] setup_slot;

    always_comb begin
        acc_idx = paddr[9:2];
        // only whole aligned words inside the low 1 KiB are mapped
        aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
        hit_setup = aligned && (acc_idx >= scb_pkg::IDX_SETUP_BASE)
            && (acc_idx < scb_pkg::IDX_SETUP_BASE + 8'(NUM_SETUPS));
        hit_route = aligned && (acc_idx == scb_pkg::IDX_CHAN_ROUTE);
        hit_status = aligned && (acc_idx == scb_pkg::IDX_FE_STATUS);
        setup_slot = 3'(acc_idx - scb_pkg::IDX_SETUP_BASE);
    end

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [15:0] setup_mem [NUM_SETUPS];
    logic [15:0] next_setup_mem [NUM_SETUPS];
    logic [10:0] chan_route;
    logic [10:0] next_chan_route;
    logic wr_fire;

    always_comb begin
        wr_fire = psel && penable && pready && pwrite;
        next_setup_mem = setup_mem;
        next_chan_route = chan_route;
        if (wr_fire && hit_setup) begin
            next_setup_mem[setup_slot] = pwdata[15:0];
        end
        // route word write, reserved codes kept as written
        if (wr_fire && hit_route) begin
            next_chan_route = pwdata[10:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SETUPS; i++) begin
                setup_mem[i] <= scb_pkg::SETUP_RESET;
            end
            chan_route <= scb_pkg::CHAN_ROUTE_RESET;
        end else begin
            setup_mem <= next_setup_mem;
            chan_route <= next_chan_route;
        end
    end

    // ------------------------------------------------------------------
    // active setup and decode
    // ------------------------------------------------------------------
    logic [2:0] setup_sel;
    logic [15:0] active_word;
    logic [17:0] dec_src0;
    logic [17:0] dec_src1;
    logic [11:0] dec_burn;
    logic dec_refpos;
    logic dec_refneg;
    logic [1:0] dec_ref_pair;
    logic dec_bypass;
    logic [7:0] dec_gain;
    logic [7:0] dec_pin0;
    logic [7:0] dec_pin1;
    logic rsvd0;
    logic rsvd1;

    always_comb begin
        setup_sel = chan_route[scb_pkg::SETUP_SEL_LSB +: 3];
        // channel picks its setup; a slot beyond the bank reads as reset
        active_word = (32'(setup_sel) < 32'(NUM_SETUPS)) ? setup_mem[setup_sel]
            : scb_pkg::SETUP_RESET;
    end

    scb_setup_decode u_setup_decode (
        .setup_word(active_word),
        .src0_na(dec_src0),
        .src1_na(dec_src1),
        .burnout_na(dec_burn),
        .refpos_en(dec_refpos),
        .refneg_en(dec_refneg),
        .ref_pair(dec_ref_pair),
        .bypass(dec_bypass),
        .gain(dec_gain)
    );

    scb_route_decode u_route0 (
        .route_code(chan_route[scb_pkg::SRC0_ROUTE_LSB +: 4]),
        .source_on(dec_src0 != scb_pkg::CUR_OFF),
        .pin_en(dec_pin0),
        .route_reserved(rsvd0)
    );

    scb_route_decode u_route1 (
        .route_code(chan_route[scb_pkg::SRC1_ROUTE_LSB +: 4]),
        .source_on(dec_src1 != scb_pkg::CUR_OFF),
        .pin_en(dec_pin1),
        .route_reserved(rsvd1)
    );

    // ------------------------------------------------------------------
    // front end outputs, one cycle behind the stored words
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src0_current_na <= scb_pkg::CUR_OFF;
            src1_current_na <= scb_pkg::CUR_OFF;
            burnout_current_na <= scb_pkg::BURN_OFF;
            refpos_buffer_en <= 1'b0;
            refneg_buffer_en <= 1'b0;
            ref_pair_sel <= scb_pkg::REF_EXT_PAIR_A;
            amp_bypass <= 1'b0;
            amp_gain <= 8'h01;
            src0_pin_en <= 8'h00;
            src1_pin_en <= 8'h00;
        end else begin
            src0_current_na <= dec_src0;
            src1_current_na <= dec_src1;
            burnout_current_na <= dec_burn;
            refpos_buffer_en <= dec_refpos;
            refneg_buffer_en <= dec_refneg;
            ref_pair_sel <= dec_ref_pair;
            amp_bypass <= dec_bypass;
            amp_gain <= dec_gain;
            src0_pin_en <= dec_pin0;
            src1_pin_en <= dec_pin1;
        end
    end

    // ------------------------------------------------------------------
    // apb response: answer staged in setup cycle, so one access cycle
    // ------------------------------------------------------------------
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup_phase;
    logic [31:0] status_word;

    always_comb begin
        setup_phase = psel && !penable;
        status_word = 32'h0;
        status_word[scb_pkg::ST_GAIN_LSB +: 8] = amp_gain;
        status_word[scb_pkg::ST_SRC0_RSVD_BIT] = rsvd0;
        status_word[scb_pkg::ST_SRC1_RSVD_BIT] = rsvd1;
        status_word[scb_pkg::ST_SETUP_LSB +: 3] = setup_sel;
        status_word[scb_pkg::ST_BYPASS_BIT] = amp_bypass;
        next_pready = setup_phase;
        next_pslverr = 1'b0;
        next_prdata = 32'h0;
        if (setup_phase) begin
            if (hit_setup) begin
                next_prdata = {16'h0, setup_mem[setup_slot]};
            end else if (hit_route) begin
                next_prdata = {21'h0, chan_route};
            end else if (hit_status) begin
                next_prdata = status_word;
                // status is read only
                next_pslverr = pwrite;
            end else begin
                next_pslverr = 1'b1;
            end
            if (pwrite) begin
                next_prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_setup_write_lands: assert property (
        (wr_fire && hit_setup && 32'(setup_slot) == 32'(setup_sel) && !hit_route)
            |-> ##2 amp_bypass == $past(pwdata[0], 2)
    ) else $error("setup write did not reach the amplifier bypass output");

    a_src1_low_current: assert property (
        (active_word[15:13] == 3'h7) |=> src1_current_na == 18'd100
    ) else $error("source 1 code 111 must give 100 nA");

    a_src0_fifty_ua: assert property (
        (active_word[12:10] == 3'h3) |=> src0_current_na == 18'd50000
    ) else $error("source 0 code 011 must give 50 uA");

    a_burnout_reserved_off: assert property (
        (active_word[9:8] == 2'h3) |=> burnout_current_na == 12'h000
    ) else $error("burnout code 11 must drive no current");

    a_refpos_follows: assert property (
        refpos_buffer_en == $past(active_word[7])
    ) else $error("positive reference buffer does not follow bit 7");

    a_refneg_follows: assert property (
        refneg_buffer_en == $past(active_word[6])
    ) else $error("negative reference buffer does not follow bit 6");

    a_ref_pair_sel: assert property (
        ref_pair_sel == $past(active_word[5:4])
    ) else $error("reference pair does not follow bits 5:4");

    a_gain_power_two: assert property (
        !active_word[0] |=> amp_gain == 8'(8'h01 << $past(active_word[3:1]))
    ) else $error("gain is not two to the code");

    a_bypass_unity: assert property (
        amp_bypass |-> amp_gain == 8'h01
    ) else $error("bypassed amplifier must show gain one");

    a_src0_route_pin6: assert property (
        (chan_route[3:0] == 4'he && active_word[12:10] != 3'h0) |=> src0_pin_en == 8'h40
    ) else $error("source 0 code 1110 must reach input 6");

    a_src1_route_pin4: assert property (
        (chan_route[7:4] == 4'ha && active_word[15:13] != 3'h0) |=> src1_pin_en == 8'h10
    ) else $error("source 1 code 1010 must reach input 4");

    a_route_reserved_dark: assert property (
        (chan_route[3:0] == 4'h2) |=> src0_pin_en == 8'h00
    ) else $error("reserved source 0 route must drive no pin");

    a_unmapped_errors: assert property (
        (setup_phase && !hit_setup && !hit_route && !hit_status) |=> pready && pslverr
    ) else $error("unmapped access must answer with an error");

    c_setup_write: cover property (wr_fire && hit_setup);
    c_bypass_active: cover property (amp_bypass && amp_gain == 8'h01);
    c_src_routed: cover property (src0_pin_en != 8'h00 && src1_pin_en != 8'h00);
    c_status_read: cover property (setup_phase && hit_status && !pwrite);

endmodule

// ===== core/scb_route_decode.sv
// pin routing decode for one excitation source
module scb_route_decode (
    input wire logic [3:0] route_code,
    input wire logic source_on,
    output logic [7:0] pin_en,
    output logic route_reserved
);

    logic [7:0] onehot;

    // ------------------------------------------------------------------
    // code to pin map, reserved codes drive nothing
    // ------------------------------------------------------------------
    always_comb begin
        onehot = 8'h00;
        route_reserved = 1'b0;
        case (route_code)
            4'h0: onehot = 8'h01;
            4'h1: onehot = 8'h02;
            4'h4: onehot = 8'h04;
            4'h5: onehot = 8'h08;
            4'ha: onehot = 8'h10;
            4'hb: onehot = 8'h20;
            4'he: onehot = 8'h40;
            4'hf: onehot = 8'h80;
            default: route_reserved = 1'b1;
        endcase
        // a source that is off reaches no pin
        pin_en = source_on ? onehot : 8'h00;
    end

endmodule

// ===== core/scb_setup_decode.sv
// decode of one setup word into front end controls
module scb_setup_decode (
    input wire logic [15:0] setup_word,
    output logic [17:0] src0_na,
    output logic [17:0] src1_na,
    output logic [11:0] burnout_na,
    output logic refpos_en,
    output logic refneg_en,
    output logic [1:0] ref_pair,
    output logic bypass,
    output logic [7:0] gain
);

    logic [2:0] gain_code;

    always_comb begin
        gain_code = setup_word[scb_pkg::GAIN_LSB +: 3];
        src1_na = scb_pkg::source_current_na(setup_word[scb_pkg::SRC1_MAG_LSB +: 3]);
        // unprinted source 0 codes follow the source 1 table
        src0_na = scb_pkg::source_current_na(setup_word[scb_pkg::SRC0_MAG_LSB +: 3]);
        burnout_na = scb_pkg::burnout_current_na(setup_word[scb_pkg::BURNOUT_LSB +: 2]);
        refpos_en = setup_word[scb_pkg::REFPOS_BUF_BIT];
        refneg_en = setup_word[scb_pkg::REFNEG_BUF_BIT];
        ref_pair = setup_word[scb_pkg::REF_SEL_LSB +: 2];
        bypass = setup_word[scb_pkg::BYPASS_BIT];
        gain = bypass ? 8'h01 : 8'(8'h01 << gain_code);
    end

endmodule

// ===== testbench/scb_bank_tb.sv
// self-checking bench for the setup configuration bank
module scb_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [17:0] src0_na;
    logic [17:0] src1_na;
    logic [11:0] burn_na;
    logic refp;
    logic refn;
    logic [1:0] refsel;
    logic byp;
    logic [7:0] gain;
    logic [7:0] pin0;
    logic [7:0] pin1;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    scb_bank uut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src0_current_na(src0_na),
        .src1_current_na(src1_na), .burnout_current_na(burn_na),
        .refpos_buffer_en(refp), .refneg_buffer_en(refn), .ref_pair_sel(refsel),
        .amp_bypass(byp), .amp_gain(gain), .src0_pin_en(pin0), .src1_pin_en(pin1));

    always #5 clock = ~clock;

    // ------------------------------------------------------------------
    // reference tables and helpers
    // ------------------------------------------------------------------
    function automatic logic [17:0] cur(input logic [2:0] c);
        logic [17:0] t [8] = '{18'd0, 18'd10000, 18'd20000, 18'd50000,
            18'd100000, 18'd150000, 18'd200000, 18'd100};
        return t[c];
    endfunction

    function automatic logic [7:0] pin(input logic [3:0] r);
        case (r)
            4'h0: return 8'h01;
            4'h1: return 8'h02;
            4'h4: return 8'h04;
            4'h5: return 8'h08;
            4'ha: return 8'h10;
            4'hb: return 8'h20;
            4'he: return 8'h40;
            4'hf: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [11:0] sa(input int i);
        return 12'h064 + 12'(i * 4);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------------
    // apb master: request held until pready is sampled high
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // if pready never comes, only the bench timeout ends this wait
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        chk("access_cycles", 32'h1, 32'(n));
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // outputs follow a stored word one edge later, so wait it out
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk("wr_err", {31'h0, ee}, {31'h0, e});
        @(posedge clock);
        #1;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("rdata", x, q);
        chk("rd_err", {31'h0, ee}, {31'h0, e});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk("gain", 32'h1, 32'(gain));
        chk("src0", 32'h0, 32'(src0_na));
        chk("src1", 32'h0, 32'(src1_na));
        chk("fe", 32'h0, {15'h0, burn_na, refp, refn, refsel, byp});
        chk("pins", 32'h0, {16'h0, pin0, pin1});
        for (int i = 0; i < 8; i++) rdc(sa(i), 32'h0, 1'b0);
        rdc(12'h0c0, 32'h0, 1'b0);
    endtask

    task automatic t_fields;
        logic [2:0] k;
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            wr(12'h064, {16'h0, k, k, k[1:0], k[0], k[1], k[1:0], k, 1'b0}, 1'b0);
            chk("src1", 32'(cur(k)), 32'(src1_na));
            chk("src0", 32'(cur(k)), 32'(src0_na));
            chk("burn", k[1:0] == 2'h1 ? 32'd500 : k[1:0] == 2'h2 ? 32'd2000 : 32'd0,
                32'(burn_na));
            chk("refp", 32'(k[0]), 32'(refp));
            chk("refn", 32'(k[1]), 32'(refn));
            chk("refsel", 32'(k[1:0]), 32'(refsel));
            chk("gain", 32'h1 << k, 32'(gain));
            chk("byp", 32'h0, 32'(byp));
            chk("pin0", k != 3'h0 ? 32'h1 : 32'h0, 32'(pin0));
            chk("pin1", k != 3'h0 ? 32'h1 : 32'h0, 32'(pin1));
        end
    endtask

    task automatic t_bypass;
        wr(12'h064, 32'h0000_000f, 1'b0);
        chk("gain", 32'h1, 32'(gain));
        chk("byp", 32'h1, 32'(byp));
        rdc(12'h064, 32'h0000_000f, 1'b0);
        rdc(12'h0c4, 32'h0000_2001, 1'b0);
    endtask

    task automatic t_route;
        logic [3:0] r;
        wr(12'h064, 32'h0000_2400, 1'b0);
        for (int i = 0; i < 16; i++) begin
            r = 4'(i);
            wr(12'h0c0, {24'h0, r, ~r}, 1'b0);
            chk("pin0", 32'(pin(~r)), 32'(pin0));
            chk("pin1", 32'(pin(r)), 32'(pin1));
            rdc(12'h0c0, {24'h0, r, ~r}, 1'b0);
            // reserved codes are kept and flagged in the status word
            rdc(12'h0c4, {22'h0, pin(r) == 8'h00, pin(~r) == 8'h00, 8'h01}, 1'b0);
        end
    endtask

    task automatic t_select;
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            wr(sa(i), {16'hdead, k, 9'h0, k, 1'b0}, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            rdc(sa(i), {16'h0, k, 9'h0, k, 1'b0}, 1'b0);
        end
        for (int i = 7; i >= 0; i--) begin
            k = 3'(i);
            wr(12'h0c0, {21'h0, k, 8'h00}, 1'b0);
            chk("gain", 32'h1 << k, 32'(gain));
            chk("src1", 32'(cur(k)), 32'(src1_na));
        end
    endtask

    task automatic t_errors;
        rdc(12'h084, 32'h0, 1'b1);
        rdc(12'h065, 32'h0, 1'b1);
        wr(12'h060, 32'h1, 1'b1);
        wr(12'h0c4, 32'h1, 1'b1);
        wr(12'h464, 32'hffff, 1'b1);
        rdc(12'h064, 32'h0, 1'b0);
        rdc(12'h0c4, 32'h1, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // about 350 cycles expected, so this only trips on a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            $display("MISMATCH timeout expected done seen hung");
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset();
        t_fields();
        t_bypass();
        t_route();
        t_select();
        t_errors();
        wrap_up();
    end
endmodule
